// [hdl/odi_pkg.sv]
package odi_pkg;

    // ------------------------------------------------------------
    // time base
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 10;
    localparam logic [31:0] TIME_STEP_NS  = 32'(CLK_PERIOD_NS);
    localparam int          TIME_W        = 32;

    // ------------------------------------------------------------
    // oversampling and buffer
    // ------------------------------------------------------------
    localparam int          FACT_W        = 10;
    localparam logic [9:0]  MAX_FACTOR    = 10'h3E8;
    localparam logic [9:0]  RST_FACTOR    = 10'h001;
    localparam int          CHANNELS      = 2;
    localparam int          ADDR_W        = FACT_W + 1;
    localparam int          MEM_DEPTH     = 1 << ADDR_W;

    // ------------------------------------------------------------
    // cycle defaults and divider
    // ------------------------------------------------------------
    localparam logic [31:0] RST_PERIOD_NS = 32'h000F4240;
    localparam logic [15:0] RST_COUNT     = 16'h0000;
    localparam logic [5:0]  DIV_STEPS     = 6'h20;

    // predefined oversampling factors; anything else is implausible
    function automatic logic odi_factor_ok(input logic [9:0] f);
        case (f)
            10'h001, 10'h002, 10'h003, 10'h004, 10'h005,
            10'h008, 10'h00A, 10'h010, 10'h014, 10'h028,
            10'h032, 10'h064, 10'h0C8, 10'h190, 10'h3E8: odi_factor_ok = 1'b1;
            default: odi_factor_ok = 1'b0;
        endcase
    endfunction

endpackage

// [hdl/odi_buf_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface odi_buf_if;
    import odi_pkg::*;
    logic                  we;
    logic [ADDR_W-1:0]     waddr;
    logic [CHANNELS-1:0]   wdata;
    logic [ADDR_W-1:0]     raddr;
    logic [CHANNELS-1:0]   rdata;

    modport ctrl (output we, output waddr, output wdata, output raddr,
                  input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr,
                  output rdata);
endinterface

`default_nettype wire

// [hdl/odi_sample_mem.sv]
`timescale 1ns/1ps
`default_nettype none

// two banks of samples, bank is the top address bit; registered read
module odi_sample_mem
    import odi_pkg::*;
(
    input  wire logic    i_clk,
    odi_buf_if.mem       bus
);
    logic [CHANNELS-1:0] mem [MEM_DEPTH];
    logic [CHANNELS-1:0] rdata;

    always_ff @(posedge i_clk) begin
        if (bus.we) begin
            mem[bus.waddr] <= bus.wdata;
        end
        rdata <= mem[bus.raddr];
    end

    assign bus.rdata = rdata;
endmodule

`default_nettype wire

// [hdl/odi_top.sv]
`timescale 1ns/1ps
`default_nettype none

module odi_top
    import odi_pkg::*;
(
    input  wire logic               i_clk,
    input  wire logic               i_rst_n,
    input  wire logic [1:0]         i_in,
    input  wire logic               i_time_load,
    input  wire logic [31:0]        i_time_value,
    input  wire logic               i_cfg_load,
    input  wire logic [9:0]         i_cfg_factor,
    input  wire logic [31:0]        i_cfg_period,
    input  wire logic [9:0]         i_rd_addr,
    output logic                    o_sample_strobe,
    output logic                    o_cycle_strobe,
    output logic [1:0]              o_rd_data,
    output logic [15:0]             o_cycle_count,
    output logic [31:0]             o_next_cycle_strobe_time,
    output logic [31:0]             o_local_time,
    output logic [9:0]              o_pkt_len,
    output logic                    o_cfg_busy,
    output logic                    o_cfg_plausible
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  in_m;
        logic [1:0]  in_s;
        logic [31:0] now;
        logic [31:0] next_cyc;
        logic [31:0] next_smp;
        logic [31:0] sper;
        logic [9:0]  factor;
        logic [31:0] p_period;
        logic [31:0] p_sper;
        logic [9:0]  p_factor;
        logic [9:0]  idx;
        logic        bank;
        logic [15:0] count;
        logic [9:0]  pkt_len;
        logic [31:0] next_cs_time;
        logic        cyc;
        logic        smp;
        logic        div_busy;
        logic [5:0]  div_cnt;
        logic [31:0] rem;
        logic [31:0] quo;
        logic [9:0]  div_d;
        logic [31:0] div_n;
        logic        plaus;
        logic        cfg_seen;
    } odi_state_t;

    localparam odi_state_t RST_STATE = '{
        in_m: 2'h0, in_s: 2'h0, now: 32'h0, next_cyc: 32'h0,
        next_smp: 32'h0, sper: RST_PERIOD_NS, factor: RST_FACTOR,
        p_period: RST_PERIOD_NS, p_sper: RST_PERIOD_NS,
        p_factor: RST_FACTOR, idx: 10'h0, bank: 1'b0, count: RST_COUNT,
        pkt_len: RST_FACTOR, next_cs_time: 32'h0, cyc: 1'b0, smp: 1'b0,
        div_busy: 1'b0, div_cnt: 6'h0, rem: 32'h0, quo: 32'h0,
        div_d: 10'h0, div_n: 32'h0, plaus: 1'b1, cfg_seen: 1'b0};

    odi_state_t          s;
    odi_state_t          next_s;
    odi_buf_if           bus ();
    logic [31:0]         cyc_diff;
    logic [31:0]         smp_diff;
    logic                cyc_hit;
    logic                smp_hit;
    logic                wr_en;
    logic [ADDR_W-1:0]   wr_addr;
    logic [31:0]         rsh;

    // signed distance handles the wrap of the 32-bit time
    assign cyc_diff = s.now - s.next_cyc;
    assign smp_diff = s.now - s.next_smp;
    assign cyc_hit  = ~cyc_diff[31];
    assign smp_hit  = ~smp_diff[31] && (s.idx < s.factor);
    assign rsh      = {s.rem[30:0], s.quo[31]};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s      = s;
        wr_en       = 1'b0;
        wr_addr     = '0;
        next_s.in_m = i_in;
        next_s.in_s = s.in_m;
        next_s.cyc  = 1'b0;
        next_s.smp  = 1'b0;
        // time base only ever steps forward, or is realigned by the master
        if (i_time_load) begin
            next_s.now = i_time_value;
        end else begin
            next_s.now = s.now + TIME_STEP_NS;
        end
        if (cyc_hit) begin
            // new settings take effect only at a cycle boundary
            next_s.cyc          = 1'b1;
            next_s.smp          = 1'b1;
            next_s.next_cyc     = s.next_cyc + s.p_period;
            next_s.next_cs_time = s.next_cyc + s.p_period;
            next_s.next_smp     = s.next_cyc + s.p_sper;
            next_s.sper         = s.p_sper;
            next_s.factor       = s.p_factor;
            next_s.pkt_len      = s.factor;
            next_s.idx          = 10'h001;
            next_s.bank         = ~s.bank;
            next_s.count        = s.count + 16'h0001;
            wr_en               = 1'b1;
            wr_addr             = {~s.bank, 10'h000};
        end else if (smp_hit) begin
            next_s.smp      = 1'b1;
            next_s.idx      = s.idx + 10'h001;
            next_s.next_smp = s.next_smp + s.sper;
            wr_en           = 1'b1;
            wr_addr         = {s.bank, s.idx};
        end
        // --------------------------------------------------------
        // factor check: period / factor must be a whole ns count
        // --------------------------------------------------------
        if (s.div_busy) begin
            if (s.div_cnt == DIV_STEPS) begin
                next_s.div_busy = 1'b0;
                next_s.p_period = s.div_n;
                if (odi_factor_ok(s.div_d) && s.rem == 32'h0) begin
                    next_s.plaus    = 1'b1;
                    next_s.p_factor = s.div_d;
                    next_s.p_sper   = s.quo;
                end else begin
                    next_s.plaus    = 1'b0;
                    next_s.p_factor = RST_FACTOR;
                    next_s.p_sper   = s.div_n;
                end
            end else begin
                next_s.div_cnt = s.div_cnt + 6'h01;
                if (rsh >= {22'h0, s.div_d}) begin
                    next_s.rem = rsh - {22'h0, s.div_d};
                    next_s.quo = {s.quo[30:0], 1'b1};
                end else begin
                    next_s.rem = rsh;
                    next_s.quo = {s.quo[30:0], 1'b0};
                end
            end
        end else if (i_cfg_load) begin
            // a load during a running check is ignored
            next_s.div_busy = 1'b1;
            next_s.cfg_seen = 1'b1;
            next_s.div_cnt  = 6'h0;
            next_s.rem      = 32'h0;
            next_s.quo      = i_cfg_period;
            next_s.div_n    = i_cfg_period;
            next_s.div_d    = i_cfg_factor;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= RST_STATE;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // sample memory, read side is the completed bank except at a cycle hit, which writes sample 0 into it
    // ------------------------------------------------------------
    assign bus.we    = wr_en;
    assign bus.waddr = wr_addr;
    assign bus.wdata = s.in_s;
    assign bus.raddr = {~s.bank, i_rd_addr};

    odi_sample_mem odi_sample_mem_i (
        .i_clk (i_clk),
        .bus   (bus.mem)
    );

    assign o_rd_data                = bus.rdata;
    assign o_sample_strobe          = s.smp;
    assign o_cycle_strobe           = s.cyc;
    assign o_cycle_count            = s.count;
    assign o_next_cycle_strobe_time = s.next_cs_time;
    assign o_local_time             = s.now;
    assign o_pkt_len                = s.pkt_len;
    assign o_cfg_busy               = s.div_busy;
    assign o_cfg_plausible          = s.plaus;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_time_step_wrap: assert property (
        !$past(i_time_load) && !$past(!i_rst_n)
        |-> o_local_time == $past(o_local_time) + TIME_STEP_NS)
        else $error("local time did not advance by one clock period");
    a_cycle_first_sample: assert property (
        o_cycle_strobe |-> o_sample_strobe
        && o_next_cycle_strobe_time == s.next_cyc)
        else $error("cycle strobe without first sample or wrong next time");
    a_cycle_count_step: assert property (
        o_cycle_strobe |-> o_cycle_count == $past(o_cycle_count) + 16'h0001)
        else $error("cycle count did not step by one");
    a_count_only_cycle: assert property (
        !o_cycle_strobe |-> $stable(o_cycle_count) && $stable(s.bank))
        else $error("count or bank changed outside a cycle strobe");
    a_sample_bound: assert property (
        s.idx <= s.factor && s.factor >= RST_FACTOR
        && s.factor <= MAX_FACTOR)
        else $error("sample index or factor out of range");
    a_sample_write: assert property (
        o_sample_strobe && !o_cycle_strobe
        |-> $past(wr_en) && $past(wr_addr[ADDR_W-1]) == s.bank
        && s.idx == $past(s.idx) + 10'h001)
        else $error("sample strobe without an ordered buffer write");
    a_packet_length: assert property (
        o_cycle_strobe |-> o_pkt_len == $past(s.factor))
        else $error("published length does not match the factor");
    a_default_factor: assert property (
        !s.cfg_seen |-> s.factor == RST_FACTOR && s.p_factor == RST_FACTOR)
        else $error("factor not one before any configuration");
    a_implausible_one: assert property (
        !s.div_busy && !s.plaus |-> s.p_factor == RST_FACTOR)
        else $error("implausible factor not forced to one");
    a_read_bank_apart: assert property (
        wr_en |-> wr_addr[ADDR_W-1] != bus.raddr[ADDR_W-1]
        || cyc_hit)
        else $error("write landed in the published bank");

endmodule

`default_nettype wire

// [dv/odi_master_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// fieldbus master: fetches the whole packet after each cycle strobe
// ------------------------------------------------------------
module odi_master_model (
    input  wire logic       i_clk,
    input  wire logic       i_cycle_strobe,
    input  wire logic [9:0] i_pkt_len,
    input  wire logic [1:0] i_rd_data,
    output logic [9:0]      o_rd_addr
);
    logic [1:0] pkt [0:1023];
    int         reads;
    int         len;

    initial begin
        o_rd_addr = 10'h000;
        reads = 0;
        forever begin
            @(negedge i_clk);
            if (i_cycle_strobe === 1'b1) begin
                len = int'(i_pkt_len);
                // three clocks a bit: slow, but far from the next bank swap
                for (int k = 0; k < len; k++) begin
                    @(negedge i_clk);
                    o_rd_addr = 10'(k);
                    @(negedge i_clk);
                    @(negedge i_clk);
                    pkt[k] = i_rd_data;
                end
                reads++;
            end
        end
    end
endmodule

`default_nettype wire

// [dv/oversampled_digital_input_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module oversampled_digital_input_tb_top;
    import odi_pkg::*;
    logic        i_clk, i_rst_n, i_time_load, i_cfg_load;
    logic [1:0]  i_in, o_rd_data;
    logic [31:0] i_time_value, i_cfg_period, o_next_cycle_strobe_time;
    logic [31:0] o_local_time;
    logic [9:0]  i_cfg_factor, i_rd_addr, o_pkt_len;
    logic        o_sample_strobe, o_cycle_strobe, o_cfg_busy, o_cfg_plausible;
    logic [15:0] o_cycle_count;
    int          error_cnt, check_count, cycles, r;
    logic [9:0]  facts [15] = '{10'h001, 10'h002, 10'h003, 10'h004, 10'h005,
        10'h008, 10'h00A, 10'h010, 10'h014, 10'h028, 10'h032, 10'h064,
        10'h0C8, 10'h190, 10'h3E8};
    logic [1:0]  exp_pkt [4] = '{2'h1, 2'h1, 2'h2, 2'h2};

    odi_top odi_top_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_in(i_in),
        .i_time_load(i_time_load), .i_time_value(i_time_value),
        .i_cfg_load(i_cfg_load), .i_cfg_factor(i_cfg_factor),
        .i_cfg_period(i_cfg_period), .i_rd_addr(i_rd_addr),
        .o_sample_strobe(o_sample_strobe), .o_cycle_strobe(o_cycle_strobe),
        .o_rd_data(o_rd_data), .o_cycle_count(o_cycle_count),
        .o_next_cycle_strobe_time(o_next_cycle_strobe_time),
        .o_local_time(o_local_time), .o_pkt_len(o_pkt_len),
        .o_cfg_busy(o_cfg_busy), .o_cfg_plausible(o_cfg_plausible));

    odi_master_model odi_master_model_i (.i_clk(i_clk),
        .i_cycle_strobe(o_cycle_strobe), .i_pkt_len(o_pkt_len),
        .i_rd_data(o_rd_data), .o_rd_addr(i_rd_addr));

    always #5 i_clk = ~i_clk;

    task automatic report_and_stop();
        if (error_cnt == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // ------------------------------------------------------------
    // hang guard
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    task automatic configure(input logic [9:0] f, input logic [31:0] p,
                             input logic ok);
        int n;
        @(negedge i_clk);
        i_cfg_factor = f;
        i_cfg_period = p;
        i_cfg_load = 1'b1;
        @(negedge i_clk);
        i_cfg_load = 1'b0;
        @(negedge i_clk);
        n = 0;
        while (o_cfg_busy === 1'b1 && n < 100) begin
            @(negedge i_clk);
            n++;
        end
        // busy stands DIV_STEPS + 1 clocks, counting starts one clock in
        check("busy cycles", 32'(n), 32'(DIV_STEPS));
        check("plausible", 32'(o_cfg_plausible), 32'(ok));
    endtask

    // gap 0 skips the spacing and count checks (cycle entered mid-way)
    task automatic next_cycle(input int samples, input int gap);
        int n, s, last;
        n = 0;
        s = 0;
        last = -1;
        @(negedge i_clk);
        while (o_cycle_strobe !== 1'b1 && n < 2000) begin
            if (o_sample_strobe === 1'b1) begin
                s++;
                if (gap > 0) check("sample gap", 32'(n - last), 32'(gap));
                last = n;
            end
            @(negedge i_clk);
            n++;
        end
        if (gap > 0) begin
            // the opening cycle strobe was sample 0 of this cycle
            check("samples", 32'(s + 1), 32'(samples));
            check("last gap", 32'(n - last), 32'(gap));
        end
        check("cycle on sample", 32'(o_sample_strobe), 32'h1);
    endtask

    initial begin
        {i_clk, i_rst_n, i_time_load, i_cfg_load} = 4'h0;
        {error_cnt, check_count, cycles} = '0;
        i_in = 2'h1;
        i_time_value = 32'h0;
        i_cfg_factor = 10'h001;
        i_cfg_period = 32'h0;
        repeat (10) @(negedge i_clk);
        i_rst_n = 1'b1;
        @(negedge i_clk);
        check("first strobe", 32'(o_cycle_strobe), 32'h1);
        check("count", 32'(o_cycle_count), 32'h1);
        check("len", 32'(o_pkt_len), 32'h1);
        configure(10'h004, 32'h320, 1'b1);
        @(negedge i_clk);
        i_time_load = 1'b1;
        i_time_value = 32'h000F422C;
        @(negedge i_clk);
        i_time_load = 1'b0;
        next_cycle(0, 0);
        check("count", 32'(o_cycle_count), 32'h2);
        check("next time", o_next_cycle_strobe_time, 32'h000F4560);
        check("len", 32'(o_pkt_len), 32'h1);
        r = odi_master_model_i.reads;
        fork
            begin
                repeat (30) @(negedge i_clk);
                i_in = 2'h2;
            end
        join_none
        next_cycle(4, 20);
        i_in = 2'h3;
        check("count", 32'(o_cycle_count), 32'h3);
        check("len", 32'(o_pkt_len), 32'h4);
        for (int k = 0; k < 40 && odi_master_model_i.reads == r + 1; k++) begin
            @(negedge i_clk);
        end
        foreach (exp_pkt[k]) begin
            check("packet bit", 32'(odi_master_model_i.pkt[k]),
                  32'(exp_pkt[k]));
        end
        configure(10'h003, 32'h320, 1'b0);
        next_cycle(0, 0);
        check("len", 32'(o_pkt_len), 32'h4);
        next_cycle(1, 80);
        check("len", 32'(o_pkt_len), 32'h1);
        foreach (facts[k]) begin
            configure(facts[k], 32'h1770, 1'b1);
        end
        configure(10'h000, 32'h1770, 1'b0);
        configure(10'h006, 32'h1770, 1'b0);
        @(negedge i_clk);
        i_time_load = 1'b1;
        i_time_value = 32'hFFFFFFF6;
        @(negedge i_clk);
        i_time_load = 1'b0;
        check("time", o_local_time, 32'hFFFFFFF6);
        @(negedge i_clk);
        check("time wrap", o_local_time, 32'h0);
        report_and_stop();
    end
endmodule

`default_nettype wire
